/* File: design/dac_ctrl_pkg.sv */
// shared constants, types and state codes for the quad dac serial controller
package dac_ctrl_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 5;
  // least low time on chip select before it counts as a deselect
  localparam int CS_FILTER_NS = 30;
  localparam int CS_FILTER_CYCLES = (CS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // typical erase/write time; the cycle must stay under STORE_MAX_NS
  localparam int STORE_TIME_NS = 3300000;
  localparam int STORE_MAX_NS = 5000000;
  localparam int STORE_CYCLES_DEF = STORE_TIME_NS / CLK_PERIOD_NS;
  localparam int STORE_CYCLES_MAX = STORE_MAX_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // frame layout
  // ***************************************************************
  localparam int CHANNELS = 4;
  localparam int LEVEL_W = 8;
  localparam int ADDR_W = 2;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_ADDR_IDX = 3'h1;
  localparam logic [BIT_CNT_W-1:0] LAST_DATA_IDX = 3'h7;
  localparam logic START_BIT = 1'b1;
  // plain default for the stored settings after power-up
  localparam logic [LEVEL_W-1:0] NV_INIT_LEVEL = 8'h80;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef logic [CHANNELS-1:0][LEVEL_W-1:0] level_bank_t;

  typedef struct packed {
    logic sclk;
    logic cs;
    logic din;
    logic store_req;
    logic supply_ok;
  } pins_s;

  localparam pins_s PINS_RESET = '0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_GAP = 5'h08,
    ST_BUSY = 5'h10
  } frame_state_e;

endpackage : dac_ctrl_pkg

/* File: design/cs_glitch_filter.sv */
// chip select low-glitch filter
`timescale 1ns/1ps
module cs_glitch_filter
  import dac_ctrl_pkg::*;
#(
  parameter int FILTER_CYCLES = CS_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_sync,
  output logic cs_live
);

  logic [7:0] low_cnt;

  // ***************************************************************
  // filter
  // ***************************************************************
  // rising select passes at once; only a low that outlasts the window deselects
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_live <= 1'b0;
      low_cnt <= 8'h00;
    end else if (cs_sync) begin
      cs_live <= 1'b1;
      low_cnt <= 8'h00;
    end else if (cs_live) begin
      if (low_cnt == 8'(FILTER_CYCLES - 1)) begin
        cs_live <= 1'b0;
        low_cnt <= 8'h00;
      end else begin
        low_cnt <= low_cnt + 8'h01;
      end
    end
  end

  AST_CS_GLITCH: assert property (@(posedge clk) disable iff (!rstn)
    cs_live && cs_sync ##1 (!cs_sync) [*5] |-> cs_live)
    else $error("short chip select low glitch deselected the device");

  COV_CS_DROP: cover property (@(posedge clk) disable iff (!rstn) $fell(cs_live));

endmodule : cs_glitch_filter

/* File: design/nv_store.sv */
// nonvolatile setting store with timed erase/write cycle
`timescale 1ns/1ps
module nv_store
  import dac_ctrl_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [ADDR_W-1:0] chan,
  input wire logic [LEVEL_W-1:0] level,
  output logic busy,
  output level_bank_t stored
);

  localparam int CNT_W = $clog2(STORE_CYCLES + 1);

  logic [LEVEL_W-1:0] nv_mem [CHANNELS];
  logic [CNT_W-1:0] write_cnt;
  logic [ADDR_W-1:0] pend_chan;
  logic [LEVEL_W-1:0] pend_level;

  // ***************************************************************
  // erase/write timer
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      write_cnt <= '0;
      pend_chan <= '0;
      pend_level <= '0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      write_cnt <= CNT_W'(STORE_CYCLES - 1);
      pend_chan <= chan;
      pend_level <= level;
    end else if (busy) begin
      if (write_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        write_cnt <= write_cnt - CNT_W'(1);
      end
    end
  end

  // ***************************************************************
  // cells
  // ***************************************************************
  // cells keep the old value until the cycle ends, so a reload mid-cycle is safe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        nv_mem[i] <= NV_INIT_LEVEL;
      end
    end else if (busy && write_cnt == '0) begin
      nv_mem[pend_chan] <= pend_level;
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      stored[i] = nv_mem[i];
    end
  end

endmodule : nv_store

/* File: design/dac_serial_ctrl.sv */
// serial control core of a quad 8-bit dac with stored settings
`timescale 1ns/1ps
module dac_serial_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DEF,
  parameter int FILTER_CYCLES = CS_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic chip_select,
  input wire logic serial_in,
  input wire logic store_request,
  input wire logic supply_ok,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic store_ready_flag,
  output level_bank_t dac_level
);

  pins_s pin_meta;
  pins_s pin_sync;
  logic sclk_prev;
  logic cs_live;
  logic sclk_rise;
  logic nv_busy;
  level_bank_t nv_level;
  frame_state_e state;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [ADDR_W-1:0] addr_sh;
  logic [LEVEL_W-1:0] data_sh;
  logic [LEVEL_W-1:0] out_sh;
  logic gap_cnt;
  logic stage_valid;
  logic [ADDR_W-1:0] stage_chan;
  logic [LEVEL_W-1:0] stage_level;
  logic [ADDR_W-1:0] next_addr;
  logic [LEVEL_W-1:0] next_data;
  logic commit;
  logic store_go;
  logic load_out;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  // all pins share one chain so data and clock keep their relative skew
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= PINS_RESET;
      pin_sync <= PINS_RESET;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta <= {serial_clk, chip_select, serial_in, store_request, supply_ok};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync.sclk;
    end
  end

  cs_glitch_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_cs_filter (
    .clk(clk),
    .rstn(rstn),
    .cs_sync(pin_sync.cs),
    .cs_live(cs_live)
  );

  // serial clock edges count only while selected
  assign sclk_rise = pin_sync.sclk && !sclk_prev && cs_live;
  assign next_addr = {pin_sync.din, addr_sh[1]};
  assign next_data = {pin_sync.din, data_sh[LEVEL_W-1:1]};
  assign commit = sclk_rise && state == ST_GAP && !gap_cnt;
  assign store_go = commit && stage_valid && pin_sync.store_req && pin_sync.supply_ok;
  assign load_out = sclk_rise && state == ST_ADDR && bit_cnt == LAST_ADDR_IDX;

  nv_store #(
    .STORE_CYCLES(STORE_CYCLES)
  ) u_nv_store (
    .clk(clk),
    .rstn(rstn),
    .start(store_go),
    .chan(stage_chan),
    .level(stage_level),
    .busy(nv_busy),
    .stored(nv_level)
  );

  // ***************************************************************
  // frame sequencer
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      addr_sh <= '0;
      data_sh <= '0;
      gap_cnt <= 1'b0;
      stage_valid <= 1'b0;
      stage_chan <= '0;
      stage_level <= '0;
    end else if (state == ST_BUSY) begin
      // serial input is not looked at while the cells are written
      if (!nv_busy) begin
        state <= ST_IDLE;
      end
    end else if (!cs_live) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      stage_valid <= 1'b0;
    end else if (sclk_rise) begin
      case (state)
        ST_IDLE: begin
          if (pin_sync.din == START_BIT) begin
            state <= ST_ADDR;
            bit_cnt <= '0;
          end
        end
        ST_ADDR: begin
          addr_sh <= next_addr;
          if (bit_cnt == LAST_ADDR_IDX) begin
            state <= ST_DATA;
            bit_cnt <= '0;
          end else begin
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        ST_DATA: begin
          data_sh <= next_data;
          if (bit_cnt == LAST_DATA_IDX) begin
            state <= ST_GAP;
            gap_cnt <= 1'b0;
            stage_valid <= 1'b1;
            stage_chan <= addr_sh;
            stage_level <= next_data;
          end else begin
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        ST_GAP: begin
          if (!gap_cnt) begin
            if (store_go) begin
              state <= ST_BUSY;
              stage_valid <= 1'b0;
            end else begin
              gap_cnt <= 1'b1;
            end
          end else begin
            state <= ST_IDLE;
            stage_valid <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // channel registers
  // ***************************************************************
  // reload repeats every cycle while deselected, tracking a finished store
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dac_level[i] <= NV_INIT_LEVEL;
      end
    end else if (!cs_live) begin
      dac_level <= nv_level;
    end else if (commit) begin
      dac_level[stage_chan] <= stage_level;
    end
  end

  // ***************************************************************
  // serial output
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      out_sh <= '0;
    end else begin
      serial_out_oe_n <= !(cs_live && state != ST_BUSY && !store_go);
      if (load_out) begin
        out_sh <= dac_level[next_addr] >> 1;
        serial_out <= dac_level[next_addr][0];
      end else if (sclk_rise && state == ST_DATA) begin
        serial_out <= out_sh[0];
        out_sh <= out_sh >> 1;
      end
    end
  end

  // ***************************************************************
  // ready flag
  // ***************************************************************
  // a refused store under low supply never raises store_go, so ready stays high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_ready_flag <= 1'b1;
    end else begin
      store_ready_flag <= !(store_go || nv_busy);
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  logic old_bit0;
  logic [31:0] busy_len;

  assign old_bit0 = dac_level[next_addr][0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_len <= 32'h0;
    end else if (nv_busy) begin
      busy_len <= busy_len + 32'h1;
    end else begin
      busy_len <= 32'h0;
    end
  end

  AST_CS_RELOAD: assert property (@(posedge clk) disable iff (!rstn)
    !cs_live |=> dac_level == $past(nv_level))
    else $error("channels not reloaded from store while deselected");

  AST_OE_DESELECT: assert property (@(posedge clk) disable iff (!rstn)
    !cs_live |=> serial_out_oe_n)
    else $error("serial output driven while deselected");

  AST_BUSY_READY: assert property (@(posedge clk) disable iff (!rstn)
    store_go |=> !store_ready_flag ##1 (nv_busy && !store_ready_flag))
    else $error("ready not low after store request");

  AST_BUSY_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_BUSY && $past(state == ST_BUSY) |-> serial_out_oe_n)
    else $error("serial output active during programming");

  AST_LOW_SUPPLY: assert property (@(posedge clk) disable iff (!rstn)
    commit && pin_sync.store_req && !pin_sync.supply_ok && !nv_busy
      |=> store_ready_flag [*3])
    else $error("ready dropped although supply too low");

  AST_UPDATE_LAST: assert property (@(posedge clk) disable iff (!rstn)
    commit |=> !cs_live || dac_level[$past(stage_chan)] == $past(stage_level))
    else $error("channel did not take new setting after last data bit");

  AST_START_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_IDLE && sclk_rise && pin_sync.din != START_BIT |=> state == ST_IDLE)
    else $error("frame began without a start bit");

  AST_GAP_DROP: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_GAP && sclk_rise && gap_cnt |=> state == ST_IDLE && !stage_valid)
    else $error("staged data not dropped on second edge after last bit");

  AST_SHIFT_OLD: assert property (@(posedge clk) disable iff (!rstn)
    load_out |=> !serial_out_oe_n && serial_out == $past(old_bit0))
    else $error("old register value not shifted out after address");

  AST_STORE_LEN: assert property (@(posedge clk) disable iff (!rstn)
    busy_len <= STORE_CYCLES)
    else $error("erase/write cycle ran too long");

  // the cycle must run its full length, and never past the worst-case limit
  AST_STORE_FULL: assert property (@(posedge clk) disable iff (!rstn)
    $fell(nv_busy) |-> busy_len == STORE_CYCLES && busy_len <= STORE_CYCLES_MAX)
    else $error("erase/write cycle length wrong");

  AST_STORE_END: assert property (@(posedge clk) disable iff (!rstn)
    $fell(nv_busy) |-> ##[1:2] (store_ready_flag && state == ST_IDLE))
    else $error("ready not restored after programming");

  COV_WRITE: cover property (@(posedge clk) disable iff (!rstn) commit && !store_go);
  COV_STORE: cover property (@(posedge clk) disable iff (!rstn) $fell(nv_busy));
  COV_REFUSED: cover property (@(posedge clk) disable iff (!rstn)
    commit && pin_sync.store_req && !pin_sync.supply_ok);
  COV_RELOAD: cover property (@(posedge clk) disable iff (!rstn) $fell(cs_live));

endmodule : dac_serial_ctrl

/* File: test/dac_host_model.sv */
// host-side model that drives the serial link of the dac controller
`timescale 1ns/1ps
module dac_host_model (
  input wire logic clk,
  input wire logic serial_out,
  output logic serial_clk,
  output logic chip_select,
  output logic serial_in,
  output logic store_request
);
  // ***************************************************************
  // pin drive
  // ***************************************************************
  initial begin
    serial_clk = 1'b0;
    chip_select = 1'b0;
    serial_in = 1'b0;
    store_request = 1'b0;
  end

  // one serial period is 16 clk; data settles 2 clk ahead of the rise
  // because the pins are resynchronised inside the controller
  task automatic sclk_pulse(input logic b, output logic so);
    serial_in <= b;
    repeat (2) @(posedge clk);
    serial_clk <= 1'b1;
    repeat (8) @(posedge clk);
    so = serial_out;
    serial_clk <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : sclk_pulse

  // clock keeps running with the data line low, also while programming
  task automatic idle_edges(input int n);
    logic so;
    for (int i = 0; i < n; i++) begin
      sclk_pulse(1'b0, so);
    end
  endtask : idle_edges

  // ***************************************************************
  // frames
  // ***************************************************************
  task automatic frame(input logic [1:0] ch, input logic [7:0] val, input logic st,
                       output logic [7:0] old);
    logic so;
    sclk_pulse(1'b1, so);
    // raised right after the start bit, far ahead of the commit edge
    store_request <= st;
    sclk_pulse(ch[0], so);
    sclk_pulse(ch[1], so);
    old[0] = so;
    for (int k = 0; k < 8; k++) begin
      sclk_pulse(val[k], so);
      if (k < 7) old[k+1] = so;
    end
    idle_edges(2);
    store_request <= 1'b0;
  endtask : frame

  task automatic select(input logic v, input int n);
    chip_select <= v;
    repeat (n) @(posedge clk);
  endtask : select
endmodule : dac_host_model

/* File: test/dac_serial_ctrl_bench.sv */
// self-checking bench for the quad dac serial controller
`timescale 1ns/1ps
module dac_serial_ctrl_bench;
  import dac_ctrl_pkg::*;
  // ***************************************************************
  // set-up
  // ***************************************************************
  // short store cycle keeps the run brief but still outlasts one frame
  localparam int STORE_N = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_ok = 1'b1;
  logic serial_clk, chip_select, serial_in, store_request;
  logic serial_out, serial_out_oe_n, store_ready_flag;
  level_bank_t dac_level;
  logic [7:0] old;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  dac_serial_ctrl #(.STORE_CYCLES(STORE_N), .FILTER_CYCLES(6)) dut (
    .clk(clk), .rstn(rstn), .serial_clk(serial_clk), .chip_select(chip_select),
    .serial_in(serial_in), .store_request(store_request), .supply_ok(supply_ok),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .store_ready_flag(store_ready_flag), .dac_level(dac_level));

  dac_host_model host (
    .clk(clk), .serial_out(serial_out), .serial_clk(serial_clk),
    .chip_select(chip_select), .serial_in(serial_in), .store_request(store_request));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ***************************************************************
  // checking
  // ***************************************************************
  task automatic chk_level(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_level

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    for (int c = 0; c < 4; c++) chk_level("reset level", 8'h80, dac_level[c]);
    chk_bit("reset ready", 1'b1, store_ready_flag);
    chk_bit("deselected oe_n", 1'b1, serial_out_oe_n);
    host.select(1'b1, 8);
    $display("done: reset");
  endtask : t_reset

  task automatic t_write_all();
    logic [7:0] vals [4];
    vals = '{8'h01, 8'h35, 8'hc4, 8'hfe};
    for (int c = 0; c < 4; c++) begin
      host.frame(2'(c), vals[c], 1'b0, old);
      chk_level("old value", 8'h80, old);
      chk_level("new level", vals[c], dac_level[c]);
    end
    for (int c = 0; c < 4; c++) chk_level("held level", vals[c], dac_level[c]);
    $display("done: write all");
  endtask : t_write_all

  task automatic t_back_to_back();
    host.frame(2'h0, 8'h6e, 1'b0, old);
    host.frame(2'h0, 8'h91, 1'b0, old);
    chk_level("back to back old", 8'h6e, old);
    chk_level("back to back level", 8'h91, dac_level[0]);
    $display("done: back to back");
  endtask : t_back_to_back

  task automatic t_start_wait();
    host.idle_edges(3);
    host.frame(2'h2, 8'h2b, 1'b0, old);
    chk_level("after zeros old", 8'hc4, old);
    chk_level("after zeros level", 8'h2b, dac_level[2]);
    $display("done: start wait");
  endtask : t_start_wait

  task automatic t_deselect();
    host.select(1'b0, 5);
    host.select(1'b1, 8);
    chk_level("glitch level", 8'h35, dac_level[1]);
    host.select(1'b0, 12);
    for (int c = 0; c < 4; c++) chk_level("restored level", 8'h80, dac_level[c]);
    chk_bit("deselect oe_n", 1'b1, serial_out_oe_n);
    host.select(1'b1, 8);
    $display("done: deselect");
  endtask : t_deselect

  task automatic t_low_supply();
    @(posedge clk);
    supply_ok <= 1'b0;
    host.frame(2'h1, 8'h77, 1'b1, old);
    chk_bit("low supply ready", 1'b1, store_ready_flag);
    host.select(1'b0, 12);
    chk_level("unstored level", 8'h80, dac_level[1]);
    host.select(1'b1, 8);
    supply_ok <= 1'b1;
    $display("done: low supply");
  endtask : t_low_supply

  task automatic t_store();
    int n;
    host.frame(2'h3, 8'h5a, 1'b1, old);
    chk_bit("busy ready", 1'b0, store_ready_flag);
    chk_bit("busy oe_n", 1'b1, serial_out_oe_n);
    host.frame(2'h2, 8'h11, 1'b0, old);
    chk_bit("still busy", 1'b0, store_ready_flag);
    chk_level("ignored frame", 8'h80, dac_level[2]);
    chk_level("kept level", 8'h5a, dac_level[3]);
    for (n = 0; n < 40 && store_ready_flag !== 1'b1; n++) host.idle_edges(1);
    chk_bit("ready again", 1'b1, store_ready_flag);
    host.frame(2'h0, 8'h42, 1'b0, old);
    chk_level("accepted after store", 8'h42, dac_level[0]);
    host.select(1'b0, 12);
    chk_level("stored level", 8'h5a, dac_level[3]);
    chk_level("unstored level", 8'h80, dac_level[0]);
    chk_level("refused store level", 8'h80, dac_level[1]);
    host.select(1'b1, 8);
    $display("done: store");
  endtask : t_store

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_write_all();
    t_back_to_back();
    t_start_wait();
    t_deselect();
    t_low_supply();
    t_store();
    report_and_stop();
  end
endmodule : dac_serial_ctrl_bench
